// file: design/subswap_pkg.sv
// Purpose: Shared constants for the subtract, swap and sleep datapath.
// Assumes: 8-bit data path, APB register window with 32-bit words.
// Notes:   Offsets are byte addresses; every register takes one aligned word.
package subswap_pkg;
    localparam int DATA_W = 8;
    // Register byte offsets.
    localparam logic [7:0] OFF_CMD      = 8'h00;
    localparam logic [7:0] OFF_ACC      = 8'h04;
    localparam logic [7:0] OFF_OPERAND  = 8'h08;
    localparam logic [7:0] OFF_RESULT   = 8'h0C;
    localparam logic [7:0] OFF_STATUS   = 8'h10;
    localparam logic [7:0] OFF_WATCHDOG = 8'h14;
    // Command register fields.
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 3;
    localparam int CMD_DEST    = 4;
    localparam int CMD_LIT_LSB = 8;
    // Operation codes.
    localparam logic [2:0] OP_NONE        = 3'h0;
    localparam logic [2:0] OP_LIT_SUB     = 3'h1;
    localparam logic [2:0] OP_REG_SUB     = 3'h2;
    localparam logic [2:0] OP_REG_SUB_BRW = 3'h3;
    localparam logic [2:0] OP_SWAP        = 3'h4;
    localparam logic [2:0] OP_SLEEP       = 3'h5;
    // Status register bit positions.
    localparam int ST_CARRY   = 0;
    localparam int ST_NIBBLE  = 1;
    localparam int ST_ZERO    = 2;
    localparam int ST_HALTED  = 3;
    localparam int ST_EXPIRY  = 4;
    localparam int ST_SLEEP   = 5;
    localparam int ST_FILE_WR = 6;
    localparam int ST_W       = 7;
    localparam logic [6:0] STATUS_RESET = 7'h18;
endpackage

// file: design/subswap_core.sv
// Purpose: Executes literal/register subtract, subtract with borrow,
//          nibble exchange and sleep on an 8-bit accumulator and flags.
// Assumes: APB slave at 25 MHz; zero wait states; software supplies the
//          addressed register value in OPERAND and collects RESULT.
// Notes:   Wake-up is by reset or by a write to STATUS clearing sleep.
//          Bus answers load from flops in the setup cycle, so a read returns
//          the register as it stood when that setup cycle ended.
//
// Contract
// - Literal subtract computes 8-bit literal minus accumulator into accumulator.
// - Register subtract computes addressed register minus accumulator.
// - Register subtract: dest 0 writes accumulator, dest 1 writes register.
// - Subtract with borrow removes accumulator and inverted carry from register.
// - Subtract with borrow: dest 0 to accumulator, dest 1 to register.
// - Nibble exchange moves low nibble high and high nibble low.
// - Nibble exchange writes register when dest is 1, else accumulator.
// - Sleep clears the halted status bit.
// - Sleep sets the expiry status bit.
// - Sleep clears watchdog counter and its prescaler.
// - After updating status, sleep stops the oscillator.
// - Literal subtract never writes a data register.
`timescale 1ns/1ps
`default_nettype none
module subswap_core #(
    parameter int PRESCALE_W = 8,
    parameter int WATCHDOG_W = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             osc_run,
    output logic             file_wr_strobe,
    output logic [7:0]       file_wr_data
);
    // Settle is the one cycle between the status update and the clock stopping.
    typedef enum logic [1:0] {RUN, SETTLE, ASLEEP} pwr_type;

    pwr_type                         pwr_reg;
    pwr_type                         pwr_next;
    logic [7:0]                      acc_reg;
    logic [7:0]                      operand_reg;
    logic [7:0]                      result_reg;
    logic                            carry_reg;
    logic                            nibble_borrow_not_bit;
    logic                            zero_reg;
    logic                            halted_status_bit;
    logic                            expiry_status_bit;
    logic                            file_wr_reg;
    logic                            pready_reg;
    logic [WATCHDOG_W-1:0]           watchdog_counter;
    logic [PRESCALE_W-1:0]           prescale_reg;
    logic                            osc_reg;
    logic                            strobe_reg;
    logic [31:0]                     rdata_reg;
    logic                            slverr_reg;

    // Bus decode. The answer flops load in the setup cycle, so the access
    // cycle finds pready, prdata and pslverr already standing: no wait state.
    wire        setup      = psel & ~penable;
    wire        access     = psel & penable & pready_reg;
    wire        wr_access  = access & pwrite;
    wire        rd_setup   = setup & ~pwrite;
    wire        hit_cmd    = (paddr == subswap_pkg::OFF_CMD);
    wire        hit_acc    = (paddr == subswap_pkg::OFF_ACC);
    wire        hit_opnd   = (paddr == subswap_pkg::OFF_OPERAND);
    wire        hit_res    = (paddr == subswap_pkg::OFF_RESULT);
    wire        hit_stat   = (paddr == subswap_pkg::OFF_STATUS);
    wire        hit_wdt    = (paddr == subswap_pkg::OFF_WATCHDOG);
    wire        mapped     = hit_cmd | hit_acc | hit_opnd | hit_res | hit_stat | hit_wdt;
    // Instructions, ACC writes and STATUS flag writes are refused while asleep; OPERAND writes and STATUS wake writes get through.
    wire        awake      = (pwr_reg == RUN);
    wire        issue      = wr_access & hit_cmd & awake;
    wire [2:0]  op         = pwdata[subswap_pkg::CMD_OP_LSB +: subswap_pkg::CMD_OP_W];
    wire        dest_file  = pwdata[subswap_pkg::CMD_DEST];
    wire [7:0]  literal    = pwdata[subswap_pkg::CMD_LIT_LSB +: 8];

    wire        is_lit     = issue & (op == subswap_pkg::OP_LIT_SUB);
    wire        is_sub     = issue & (op == subswap_pkg::OP_REG_SUB);
    wire        is_subb    = issue & (op == subswap_pkg::OP_REG_SUB_BRW);
    wire        is_swap    = issue & (op == subswap_pkg::OP_SWAP);
    wire        is_sleep   = issue & (op == subswap_pkg::OP_SLEEP);
    wire        any_sub    = is_lit | is_sub | is_subb;

    // Minuend is the literal or the addressed register.
    wire [7:0]  minuend    = is_lit ? literal : operand_reg;
    // Borrow-in is the inverted carry only for subtract with borrow.
    wire        borrow_in  = is_subb & ~carry_reg;
    // Nine-bit sum of minuend + ~acc + ~borrow: bit 8 is the no-borrow carry.
    wire [8:0]  diff_full  = {1'b0, minuend} + {1'b0, ~acc_reg} + {8'h00, ~borrow_in};
    wire [4:0]  diff_low   = {1'b0, minuend[3:0]} + {1'b0, ~acc_reg[3:0]} + {4'h0, ~borrow_in};
    wire [7:0]  diff       = diff_full[7:0];
    wire [7:0]  swapped    = {operand_reg[3:0], operand_reg[7:4]};

    // Destination choice: literal subtract always targets the accumulator.
    wire        to_file    = (is_sub | is_subb | is_swap) & dest_file & ~is_lit;
    wire        to_acc     = is_lit | ((is_sub | is_subb | is_swap) & ~dest_file);
    wire [7:0]  exec_value = is_swap ? swapped : diff;

    // Status word: bit 7 reads zero, bits 6 and 5 are read-only views.
    wire [31:0] status_word = {24'h0, 1'b0, file_wr_reg, (pwr_reg != RUN), expiry_status_bit,
                               halted_status_bit, zero_reg, nibble_borrow_not_bit, carry_reg};
    wire [31:0] rd_mux = hit_acc  ? {24'h0, acc_reg} :
                         hit_opnd ? {24'h0, operand_reg} :
                         hit_res  ? {24'h0, result_reg} :
                         hit_stat ? status_word :
                         hit_wdt  ? {{(32-WATCHDOG_W){1'b0}}, watchdog_counter} : 32'h0;
    // Besides reset, only a STATUS write with the sleep bit clear restarts the clock.
    wire        wake       = wr_access & hit_stat & ~pwdata[subswap_pkg::ST_SLEEP];

    // Power sequence: status updates in the sleep cycle, clock stops after.
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            RUN:     if (is_sleep) pwr_next = SETTLE;
            SETTLE:  pwr_next = ASLEEP;
            ASLEEP:  if (wake) pwr_next = RUN;
            default: pwr_next = RUN;
        endcase
    end

    // Accumulator, operand and result registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg     <= 8'h00;
            operand_reg <= 8'h00;
            result_reg  <= 8'h00;
        end else begin
            if (to_acc) acc_reg <= exec_value;
            else if (wr_access & hit_acc & awake) acc_reg <= pwdata[7:0];
            if (wr_access & hit_opnd) operand_reg <= pwdata[7:0];
            if (any_sub | is_swap) result_reg <= exec_value;
        end
    end

    // Arithmetic flags; swap and sleep leave them alone.
    // An instruction outranks a STATUS write, though one bus edge carries only one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_reg             <= 1'b0;
            nibble_borrow_not_bit <= 1'b0;
            zero_reg              <= 1'b0;
        end else if (any_sub) begin
            carry_reg             <= diff_full[8];
            nibble_borrow_not_bit <= diff_low[4];
            zero_reg              <= (diff == 8'h00);
        end else if (wr_access & hit_stat & awake) begin
            carry_reg             <= pwdata[subswap_pkg::ST_CARRY];
            nibble_borrow_not_bit <= pwdata[subswap_pkg::ST_NIBBLE];
            zero_reg              <= pwdata[subswap_pkg::ST_ZERO];
        end
    end

    // Power status bits and the record of the last destination.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halted_status_bit <= subswap_pkg::STATUS_RESET[subswap_pkg::ST_HALTED];
            expiry_status_bit <= subswap_pkg::STATUS_RESET[subswap_pkg::ST_EXPIRY];
            file_wr_reg       <= 1'b0;
            pwr_reg           <= RUN;
        end else begin
            pwr_reg <= pwr_next;
            if (is_sleep) begin
                halted_status_bit <= 1'b0;
                expiry_status_bit <= 1'b1;
            end
            if (any_sub | is_swap) begin
                file_wr_reg <= to_file;
            end
        end
    end

    // Watchdog and prescaler run while awake and are cleared by sleep.
    // The count freezes while the clock is stopped, so a read then shows zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter <= '0;
            prescale_reg     <= '0;
        end else if (is_sleep) begin
            watchdog_counter <= '0;
            prescale_reg     <= '0;
        end else if (awake) begin
            prescale_reg <= prescale_reg + 1'b1;
            if (&prescale_reg) watchdog_counter <= watchdog_counter + 1'b1;
        end
    end

    // Output flops: oscillator enable, file write strobe and bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_reg      <= 1'b1;
            strobe_reg   <= 1'b0;
            file_wr_data <= 8'h00;
            pready_reg   <= 1'b0;
            rdata_reg    <= 32'h0;
            slverr_reg   <= 1'b0;
        end else begin
            osc_reg    <= (pwr_next != ASLEEP);
            strobe_reg <= to_file;
            if (to_file) file_wr_data <= exec_value;
            pready_reg <= setup;
            rdata_reg  <= rd_setup ? rd_mux : 32'h0;
            slverr_reg <= setup & ~mapped;
        end
    end

    // Every bus answer comes straight from a flop; the price is that a read
    // returns the register as it stood at the end of the setup cycle.
    assign pready         = pready_reg;
    assign prdata         = rdata_reg;
    assign pslverr        = slverr_reg;
    assign osc_run        = osc_reg;
    assign file_wr_strobe = strobe_reg;

    // Literal subtract checks. Expected values are rebuilt from the operands
    // seen at the issuing edge, not taken from the adder above.
    AST_LIT_NO_FILE: assert property (@(posedge pclk) disable iff (!presetn)
        is_lit |=> !file_wr_strobe)
        else $error("Literal subtract reached the file.");
    AST_LIT_VAL: assert property (@(posedge pclk) disable iff (!presetn)
        is_lit |=> acc_reg == $past(literal) - $past(acc_reg))
        else $error("Literal subtract result wrong.");
    AST_LIT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
        is_lit |=> carry_reg == ($past(acc_reg) <= $past(literal))
            && nibble_borrow_not_bit == ($past(acc_reg[3:0]) <= $past(literal[3:0])))
        else $error("Literal subtract flags wrong.");

    // Register subtract checks for both destinations and the borrow flags.
    AST_SUB_DEST: assert property (@(posedge pclk) disable iff (!presetn)
        (is_sub && dest_file) |=> file_wr_strobe
            && file_wr_data == $past(operand_reg) - $past(acc_reg))
        else $error("Register subtract did not write the file.");
    AST_SUB_KEEP_ACC: assert property (@(posedge pclk) disable iff (!presetn)
        (is_sub && dest_file) |=> $stable(acc_reg))
        else $error("Register subtract to the file changed the accumulator.");
    AST_SUB_W: assert property (@(posedge pclk) disable iff (!presetn)
        (is_sub && !dest_file) |=> acc_reg == $past(operand_reg) - $past(acc_reg)
            && !file_wr_strobe)
        else $error("Register subtract to the accumulator wrong.");
    AST_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
        is_sub |=> carry_reg == ($past(acc_reg) <= $past(operand_reg)))
        else $error("Carry does not reflect borrow.");
    AST_SUB_NIBBLE: assert property (@(posedge pclk) disable iff (!presetn)
        is_sub |=> nibble_borrow_not_bit == ($past(acc_reg[3:0]) <= $past(operand_reg[3:0])))
        else $error("Nibble carry does not reflect borrow.");
    AST_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (is_lit || is_sub || is_subb) |=> zero_reg == (result_reg == 8'h00))
        else $error("Zero flag does not match the result.");
    AST_STROBE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        file_wr_strobe |=> !file_wr_strobe)
        else $error("File store strobe lasted more than one cycle.");

    // Subtract with borrow: the inverted carry is taken away as well.
    AST_SUBB_W: assert property (@(posedge pclk) disable iff (!presetn)
        (is_subb && !dest_file) |=> acc_reg == $past(operand_reg) - $past(acc_reg)
            - {7'h00, ~$past(carry_reg)} && !file_wr_strobe)
        else $error("Subtract with borrow result wrong.");
    AST_SUBB_FILE: assert property (@(posedge pclk) disable iff (!presetn)
        (is_subb && dest_file) |=> file_wr_strobe && file_wr_data == $past(operand_reg)
            - $past(acc_reg) - {7'h00, ~$past(carry_reg)})
        else $error("Subtract with borrow did not write the file.");
    AST_SUBB_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
        is_subb |=> carry_reg == (({1'b0, $past(acc_reg)} + {8'h00, ~$past(carry_reg)})
            <= {1'b0, $past(operand_reg)}))
        else $error("Subtract with borrow carry wrong.");
    AST_SUBB_NIBBLE: assert property (@(posedge pclk) disable iff (!presetn)
        is_subb |=> nibble_borrow_not_bit == (({1'b0, $past(acc_reg[3:0])}
            + {4'h0, ~$past(carry_reg)}) <= {1'b0, $past(operand_reg[3:0])}))
        else $error("Subtract with borrow nibble carry wrong.");

    // Nibble exchange: value, destination and untouched flags.
    AST_SWAP_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
        is_swap |=> $stable(carry_reg) && $stable(zero_reg) && $stable(nibble_borrow_not_bit))
        else $error("Swap changed a flag.");
    AST_SWAP_VAL: assert property (@(posedge pclk) disable iff (!presetn)
        (is_swap && !dest_file) |=> acc_reg
            == {$past(operand_reg[3:0]), $past(operand_reg[7:4])})
        else $error("Swap nibbles wrong.");
    AST_SWAP_FILE: assert property (@(posedge pclk) disable iff (!presetn)
        (is_swap && dest_file) |=> file_wr_strobe && $stable(acc_reg)
            && file_wr_data == {$past(operand_reg[3:0]), $past(operand_reg[7:4])})
        else $error("Swap to the file wrong.");

    // Sleep: status bits, watchdog and the oscillator stop that follows.
    AST_SLEEP_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
        is_sleep |=> !halted_status_bit && expiry_status_bit && watchdog_counter == '0)
        else $error("Sleep status update wrong.");
    AST_SLEEP_EXPIRY: assert property (@(posedge pclk) disable iff (!presetn)
        is_sleep |=> expiry_status_bit)
        else $error("Sleep did not set the expiry bit.");
    AST_SLEEP_WDT: assert property (@(posedge pclk) disable iff (!presetn)
        is_sleep |=> watchdog_counter == '0 && prescale_reg == '0)
        else $error("Sleep did not clear the watchdog.");
    AST_OSC_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        is_sleep |=> osc_run ##1 !osc_run)
        else $error("Oscillator not stopped after sleep.");
    AST_ASLEEP_ACC: assert property (@(posedge pclk) disable iff (!presetn)
        (pwr_reg == ASLEEP) |=> $stable(acc_reg))
        else $error("Accumulator changed while asleep.");
endmodule // subswap_core
`default_nettype wire

// file: tb/file_model.sv
// Purpose: Stand-in for the data register file that takes file-bound results.
// Assumes: One register store per strobe pulse.
// Notes:   Counting stores lets the bench spot a store that must never happen.
`timescale 1ns/1ps
`default_nettype none
module file_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       file_wr_strobe,
    input  wire logic [7:0] file_wr_data,
    output var  logic [7:0] last_value,
    output var  int         writes
);
    // Capture each store; a stray pulse shows up as an extra count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_value <= 8'h00;
            writes     <= 0;
        end else if (file_wr_strobe === 1'b1) begin
            last_value <= file_wr_data;
            writes     <= writes + 1;
        end
    end
endmodule // file_model
`default_nettype wire

// file: tb/tb_subtract_swap_sleep_ops.sv
// Purpose: Drives subtract, swap and sleep commands over APB and checks results.
// Assumes: Zero wait state slave; short watchdog counts for a quick run.
// Notes:   Status reads are masked to flag and power bits only.
`timescale 1ns/1ps
`default_nettype none
module tb_subtract_swap_sleep_ops;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_run, e;
    logic        file_wr_strobe;
    logic [7:0]  paddr, file_wr_data, last_value;
    logic [31:0] pwdata, prdata, r;
    int          writes;
    int          num_errors = 0;
    int          checked = 0;

    subswap_core #(.PRESCALE_W(4), .WATCHDOG_W(4)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .osc_run(osc_run),
        .file_wr_strobe(file_wr_strobe), .file_wr_data(file_wr_data));
    file_model i_file (.pclk(pclk), .presetn(presetn), .file_wr_strobe(file_wr_strobe),
        .file_wr_data(file_wr_data), .last_value(last_value), .writes(writes));

    // Free-running core clock at 25 MHz.
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic ck(input string n, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    // One APB transfer; the request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            ck("pready", 32'h1, 32'h0);
            stop_test();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        ck($sformatf("reg %h", a), x, r & m);
    endtask

    task automatic cmd(input logic [2:0] op, input logic dst, input logic [7:0] k);
        apb(1'b1, subswap_pkg::OFF_CMD, {16'h0000, k, 3'h0, dst, 1'b0, op});
        // The file model stores on the edge that ends apb; let it settle.
        @(posedge pclk);
    endtask

    // Bounded wait for the oscillator state; running out counts as a mismatch.
    task automatic wait_osc(input logic v, input int lim);
        int n;
        n = 0;
        while (osc_run !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        ck("osc_run", {31'h0, v}, {31'h0, osc_run});
    endtask

    // Main sequence: each command is followed by reads of what it must change.
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(subswap_pkg::OFF_STATUS, 32'h18, 32'h3F);
        apb(1'b1, subswap_pkg::OFF_ACC, 32'h05);
        cmd(subswap_pkg::OP_LIT_SUB, 1'b1, 8'h03);
        rc(subswap_pkg::OFF_ACC, 32'hFE, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_STATUS, 32'h18, 32'h3F);
        ck("file writes", 32'd0, writes);
        apb(1'b1, subswap_pkg::OFF_OPERAND, 32'h10);
        apb(1'b1, subswap_pkg::OFF_ACC, 32'h01);
        cmd(subswap_pkg::OP_REG_SUB, 1'b0, 8'h00);
        rc(subswap_pkg::OFF_ACC, 32'h0F, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_STATUS, 32'h19, 32'h3F);
        apb(1'b1, subswap_pkg::OFF_OPERAND, 32'h22);
        apb(1'b1, subswap_pkg::OFF_ACC, 32'h22);
        cmd(subswap_pkg::OP_REG_SUB, 1'b1, 8'h00);
        rc(subswap_pkg::OFF_ACC, 32'h22, 32'hFFFFFFFF);
        ck("file data", 32'h00, {24'h0, last_value});
        ck("file writes", 32'd1, writes);
        rc(subswap_pkg::OFF_STATUS, 32'h1F, 32'h3F);
        apb(1'b1, subswap_pkg::OFF_STATUS, 32'h00);
        apb(1'b1, subswap_pkg::OFF_OPERAND, 32'h50);
        apb(1'b1, subswap_pkg::OFF_ACC, 32'h10);
        cmd(subswap_pkg::OP_REG_SUB_BRW, 1'b1, 8'h00);
        ck("file data", 32'h3F, {24'h0, last_value});
        rc(subswap_pkg::OFF_STATUS, 32'h19, 32'h3F);
        cmd(subswap_pkg::OP_REG_SUB_BRW, 1'b0, 8'h00);
        rc(subswap_pkg::OFF_ACC, 32'h40, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_STATUS, 32'h1B, 32'h3F);
        apb(1'b1, subswap_pkg::OFF_STATUS, 32'h05);
        apb(1'b1, subswap_pkg::OFF_OPERAND, 32'hA5);
        cmd(subswap_pkg::OP_SWAP, 1'b1, 8'h00);
        ck("file data", 32'h5A, {24'h0, last_value});
        ck("file writes", 32'd3, writes);
        cmd(subswap_pkg::OP_SWAP, 1'b0, 8'h00);
        rc(subswap_pkg::OFF_ACC, 32'h5A, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_RESULT, 32'h5A, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_STATUS, 32'h1D, 32'h3F);
        apb(1'b0, 8'h18, 32'h0);
        ck("pslverr", 32'h1, {31'h0, e});
        ck("unmapped data", 32'h0, r);
        cmd(subswap_pkg::OP_SLEEP, 1'b0, 8'h00);
        rc(subswap_pkg::OFF_WATCHDOG, 32'h00, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_STATUS, 32'h35, 32'h3F);
        wait_osc(1'b0, 6);
        apb(1'b1, subswap_pkg::OFF_ACC, 32'h77);
        rc(subswap_pkg::OFF_ACC, 32'h5A, 32'hFFFFFFFF);
        apb(1'b1, subswap_pkg::OFF_STATUS, 32'h05);
        wait_osc(1'b1, 10);
        cmd(subswap_pkg::OP_LIT_SUB, 1'b0, 8'h00);
        rc(subswap_pkg::OFF_ACC, 32'hA6, 32'hFFFFFFFF);
        rc(subswap_pkg::OFF_STATUS, 32'h00, 32'h07);
        stop_test();
    end
endmodule // tb_subtract_swap_sleep_ops
`default_nettype wire
